/* File: ccic_bus_partner.sv */
// open-drain i2c lines with a far-side party that can hold sda low
`timescale 1ns/1ps
`default_nettype none
module ccic_bus_partner (
    input  wire logic hold_sda_i,
    input  wire logic scl_oe_i,
    input  wire logic sda_oe_i,
    output logic      scl_o,
    output logic      sda_o
);
    // pull-ups: a line reads high unless some party pulls it
    assign scl_o = !scl_oe_i;
    assign sda_o = !(sda_oe_i || hold_sda_i);
endmodule // ccic_bus_partner
`default_nettype wire

/* File: ccic_bus_watchdog.sv */
// i2c bus watchdog with free-bus detection and hung-bus recovery
`timescale 1ns/1ps
`default_nettype none
module ccic_bus_watchdog
    import ccic_pkg::*;
#(
    parameter int unsigned TO_SLOW = WDT_SLOW_CYC,
    parameter int unsigned TO_FAST = WDT_FAST_CYC,
    parameter int unsigned FREE    = BUS_FREE_CYC,
    parameter int unsigned HALF    = REC_HALF_CYC
) (
    input  wire logic clk_i,
    input  wire logic rstn_i,
    input  wire logic scl_i,
    input  wire logic sda_i,
    input  wire logic disable_i,
    input  wire logic fast_i,
    output logic      bus_free_o,
    output logic      recover_o,
    output logic      scl_oe_o
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        WD_IDLE = 3'b001,
        WD_LOW  = 3'b010,
        WD_HIGH = 3'b100
    } ccic_wd_e;

    ccic_wd_e    st_ff;
    ccic_wd_e    nxt_st;
    logic [23:0] cnt_ff;
    logic [23:0] nxt_cnt;
    logic [3:0]  pls_ff;
    logic [3:0]  nxt_pls;
    logic        scl_d_ff;
    logic        sda_d_ff;
    logic        free_ff;
    logic        nxt_free;
    logic        rec_ff;

    wire        activity = (scl_i != scl_d_ff) || (sda_i != sda_d_ff);
    wire [23:0] to_cyc   = fast_i ? TO_FAST[23:0] : TO_SLOW[23:0];
    wire        hung     = !sda_i && (cnt_ff >= to_cyc - 24'h1);
    wire        freed    = sda_i && (cnt_ff >= FREE[23:0] - 24'h1);
    wire        half_end = cnt_ff >= HALF[23:0] - 24'h1;
    wire        last_pls = pls_ff == 4'(REC_PULSES - 1);

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        nxt_st   = st_ff;
        nxt_cnt  = cnt_ff;
        nxt_pls  = pls_ff;
        nxt_free = free_ff;
        case (st_ff)
            WD_IDLE: begin
                if (disable_i || activity) begin
                    nxt_cnt  = 24'h0;
                    nxt_free = 1'b0;
                end else if (hung) begin
                    nxt_st  = WD_LOW;
                    nxt_cnt = 24'h0;
                    nxt_pls = 4'h0;
                end else begin
                    if (freed) begin
                        nxt_free = 1'b1;
                    end
                    // saturate so a long quiet bus stays free
                    if (cnt_ff != 24'hffffff) begin
                        nxt_cnt = cnt_ff + 24'h1;
                    end
                end
            end
            WD_LOW: begin
                nxt_cnt = cnt_ff + 24'h1;
                if (half_end) begin
                    nxt_st  = WD_HIGH;
                    nxt_cnt = 24'h0;
                end
            end
            WD_HIGH: begin
                nxt_cnt = cnt_ff + 24'h1;
                if (half_end) begin
                    nxt_cnt = 24'h0;
                    nxt_pls = pls_ff + 4'h1;
                    nxt_st  = last_pls ? WD_IDLE : WD_LOW;
                end
            end
            default: begin
                nxt_st  = WD_IDLE;
                nxt_cnt = 24'h0;
            end
        endcase
        // disabling aborts a recovery in progress
        if (disable_i && st_ff != WD_IDLE) begin
            nxt_st  = WD_IDLE;
            nxt_cnt = 24'h0;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_ff    <= WD_IDLE;
            cnt_ff   <= 24'h0;
            pls_ff   <= 4'h0;
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
            free_ff  <= 1'b0;
            rec_ff   <= 1'b0;
            scl_oe_o <= 1'b0;
        end else begin
            st_ff    <= nxt_st;
            cnt_ff   <= nxt_cnt;
            pls_ff   <= nxt_pls;
            scl_d_ff <= scl_i;
            sda_d_ff <= sda_i;
            free_ff  <= nxt_free;
            rec_ff   <= nxt_st != WD_IDLE;
            scl_oe_o <= nxt_st == WD_LOW;
        end
    end

    assign bus_free_o = free_ff;
    assign recover_o  = rec_ff;
endmodule // ccic_bus_watchdog
`default_nettype wire

/* File: ccic_pkg.sv */
// shared constants and types for the control channel configuration block
package ccic_pkg;
    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL_B    = 8'h06;
    localparam logic [7:0] OFS_SER_ADDR  = 8'h07;
    localparam logic [7:0] OFS_TGT_ADDR0 = 8'h08;
    localparam logic [7:0] OFS_TGT_ADDR1 = 8'h09;
    localparam logic [7:0] OFS_TGT_MTCH0 = 8'h10;
    localparam logic [7:0] OFS_TGT_MTCH1 = 8'h11;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int SEQ_ERR_BIT   = 7;
    localparam int SEQ_CLR_BIT   = 6;
    localparam int SDA_DLY_HI    = 4;
    localparam int SDA_DLY_LO    = 3;
    localparam int REM_WR_BLK    = 2;
    localparam int WDT_FAST_BIT  = 1;
    localparam int WDT_DIS_BIT   = 0;
    localparam int ADDR_HI       = 7;
    localparam int ADDR_LO       = 1;
    localparam int ADDR_LOCK_BIT = 0;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_CTRL_B   = 8'h00;
    localparam logic [7:0] RST_SER_ADDR = 8'h18;
    localparam logic [7:0] RST_TGT      = 8'h00;
    localparam logic [7:0] RST_MTCH     = 8'h00;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int SDA_DLY_BASE_NS = 250;
    localparam int SDA_DLY_STEP_NS = 50;
    localparam int WDT_FAST_MS  = 50;
    localparam int WDT_SLOW_MS  = 1000;
    localparam int BUS_FREE_MS  = 1000;
    localparam int REC_HALF_NS  = 5000;
    localparam int WDT_FAST_CYC = WDT_FAST_MS * 1000000 / CLK_PERIOD_NS;
    localparam int WDT_SLOW_CYC = WDT_SLOW_MS * 1000000 / CLK_PERIOD_NS;
    localparam int BUS_FREE_CYC = BUS_FREE_MS * 1000000 / CLK_PERIOD_NS;
    localparam int REC_HALF_CYC = REC_HALF_NS / CLK_PERIOD_NS;
    localparam int REC_PULSES   = 9;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       valid;
        logic [6:0] addr;
    } ccic_fwd_addr_s;

    typedef struct packed {
        logic       valid;
        logic       to_ser;
        logic       hit;
        logic [6:0] addr;
    } ccic_xlat_s;
endpackage

/* File: ccic_top.sv */
// control channel i2c configuration, address mapping and bus supervision
`timescale 1ns/1ps
`default_nettype none
module ccic_top
    import ccic_pkg::*;
#(
    parameter int unsigned WDT_SLOW = WDT_SLOW_CYC,
    parameter int unsigned WDT_FAST = WDT_FAST_CYC,
    parameter int unsigned FREE_TO  = BUS_FREE_CYC,
    parameter int unsigned REC_HALF = REC_HALF_CYC
) (
    input  wire logic           clk_i,
    input  wire logic           rstn_i,
    input  wire logic           reg_req_i,
    input  wire logic           reg_we_i,
    input  wire logic           reg_remote_i,
    input  wire logic [7:0]     reg_addr_i,
    input  wire logic [7:0]     reg_wdata_i,
    output logic [7:0]          reg_rdata_o,
    output logic                reg_ack_o,
    output logic                reg_blocked_o,
    input  wire logic           fwd_seq_err_i,
    input  wire ccic_fwd_addr_s fwd_addr_i,
    input  wire logic           xlat_req_i,
    input  wire logic [6:0]     xlat_addr_i,
    output ccic_xlat_s          xlat_o,
    input  wire logic           sda_drive_i,
    input  wire logic           scl_i,
    output logic                scl_o,
    output logic                scl_oe_o,
    input  wire logic           sda_i,
    output logic                sda_o,
    output logic                sda_oe_o,
    output logic                bus_free_o,
    output logic                recover_o
);
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic addr_match(input logic [6:0] a,
                                        input logic [7:0] field);
        // a zero field never matches, so it disables that route
        return (field[ADDR_HI:ADDR_LO] != 7'h0) &&
               (field[ADDR_HI:ADDR_LO] == a);
    endfunction

    function automatic logic [2:0] sda_dly_cyc(input logic [1:0] code);
        int ns;
        ns = SDA_DLY_BASE_NS + int'(code) * SDA_DLY_STEP_NS;
        return 3'((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    endfunction

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [7:0] ctrl_ff;
    logic [7:0] ser_ff;
    logic [7:0] tgt0_ff;
    logic [7:0] tgt1_ff;
    logic [7:0] mtch0_ff;
    logic [7:0] mtch1_ff;
    logic       seq_err_ff;
    logic       nxt_seq_err;
    logic [7:0] nxt_ser;

    wire wr_try = reg_req_i && reg_we_i;
    wire wr_blk = wr_try && reg_remote_i && ctrl_ff[REM_WR_BLK];
    wire wr_ok  = wr_try && !wr_blk;
    wire wr_ctl = wr_ok && reg_addr_i == OFS_CTRL_B;
    wire wr_ser = wr_ok && reg_addr_i == OFS_SER_ADDR;
    wire wr_t0  = wr_ok && reg_addr_i == OFS_TGT_ADDR0;
    wire wr_t1  = wr_ok && reg_addr_i == OFS_TGT_ADDR1;
    wire wr_m0  = wr_ok && reg_addr_i == OFS_TGT_MTCH0;
    wire wr_m1  = wr_ok && reg_addr_i == OFS_TGT_MTCH1;

    // set wins over the held clear so no error is lost
    always_comb begin
        nxt_seq_err = seq_err_ff;
        if (ctrl_ff[SEQ_CLR_BIT]) begin
            nxt_seq_err = 1'b0;
        end
        if (fwd_seq_err_i) begin
            nxt_seq_err = 1'b1;
        end
    end

    // a host write beats a same-cycle forward channel load
    always_comb begin
        nxt_ser = ser_ff;
        if (wr_ser) begin
            nxt_ser = reg_wdata_i;
        end else if (fwd_addr_i.valid && !ser_ff[ADDR_LOCK_BIT]) begin
            nxt_ser = {fwd_addr_i.addr, ser_ff[ADDR_LOCK_BIT]};
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_ff    <= RST_CTRL_B;
            ser_ff     <= RST_SER_ADDR;
            tgt0_ff    <= RST_TGT;
            tgt1_ff    <= RST_TGT;
            mtch0_ff   <= RST_MTCH;
            mtch1_ff   <= RST_MTCH;
            seq_err_ff <= 1'b0;
        end else begin
            // bit 7 is status and bit 5 reserved, neither stored
            if (wr_ctl) begin
                ctrl_ff <= reg_wdata_i & 8'h5f;
            end
            if (wr_t0) begin
                tgt0_ff <= reg_wdata_i & 8'hfe;
            end
            if (wr_t1) begin
                tgt1_ff <= reg_wdata_i & 8'hfe;
            end
            if (wr_m0) begin
                mtch0_ff <= reg_wdata_i & 8'hfe;
            end
            if (wr_m1) begin
                mtch1_ff <= reg_wdata_i & 8'hfe;
            end
            ser_ff     <= nxt_ser;
            seq_err_ff <= nxt_seq_err;
        end
    end

    // ----------------------------------------------------------------
    // register read port
    // ----------------------------------------------------------------
    logic [7:0] rd_mux;
    always_comb begin
        case (reg_addr_i)
            OFS_CTRL_B:    rd_mux = {seq_err_ff, ctrl_ff[6:0]};
            OFS_SER_ADDR:  rd_mux = ser_ff;
            OFS_TGT_ADDR0: rd_mux = tgt0_ff;
            OFS_TGT_ADDR1: rd_mux = tgt1_ff;
            OFS_TGT_MTCH0: rd_mux = mtch0_ff;
            OFS_TGT_MTCH1: rd_mux = mtch1_ff;
            default:       rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            reg_rdata_o   <= 8'h00;
            reg_ack_o     <= 1'b0;
            reg_blocked_o <= 1'b0;
        end else begin
            reg_ack_o     <= reg_req_i;
            reg_blocked_o <= wr_blk;
            if (reg_req_i && !reg_we_i) begin
                reg_rdata_o <= rd_mux;
            end
        end
    end

    // ----------------------------------------------------------------
    // address translation toward the serializer
    // ----------------------------------------------------------------
    // only register writes are gated; passing transactions are not
    wire       to_ser = addr_match(xlat_addr_i, ser_ff);
    wire       hit0   = addr_match(xlat_addr_i, mtch0_ff);
    wire       hit1   = addr_match(xlat_addr_i, mtch1_ff);
    wire [6:0] phys   = hit0 ? tgt0_ff[ADDR_HI:ADDR_LO] :
                               tgt1_ff[ADDR_HI:ADDR_LO];

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            xlat_o <= '0;
        end else begin
            xlat_o.valid  <= xlat_req_i;
            if (xlat_req_i) begin
                xlat_o.to_ser <= to_ser;
                xlat_o.hit    <= hit0 || hit1;
                xlat_o.addr   <= (hit0 || hit1) ? phys : xlat_addr_i;
            end
        end
    end

    // ----------------------------------------------------------------
    // pin synchronisers and sda output delay
    // ----------------------------------------------------------------
    logic [1:0] scl_sync_ff;
    logic [1:0] sda_sync_ff;
    logic [3:0] sda_pipe_ff;

    // delay is rounded up to whole clocks, so 250/300 and 350/400 share
    wire [2:0] dly_cyc = sda_dly_cyc(ctrl_ff[SDA_DLY_HI:SDA_DLY_LO]);
    wire [1:0] dly_tap = 2'(dly_cyc - 3'd2);

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            scl_sync_ff <= 2'b11;
            sda_sync_ff <= 2'b11;
            sda_pipe_ff <= 4'h0;
            sda_oe_o    <= 1'b0;
            sda_o       <= 1'b0;
            scl_o       <= 1'b0;
        end else begin
            scl_sync_ff <= {scl_sync_ff[0], scl_i};
            sda_sync_ff <= {sda_sync_ff[0], sda_i};
            sda_pipe_ff <= {sda_pipe_ff[2:0], sda_drive_i};
            sda_oe_o    <= sda_pipe_ff[dly_tap];
            sda_o       <= 1'b0;
            scl_o       <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // bus watchdog
    // ----------------------------------------------------------------
    ccic_bus_watchdog #(
        .TO_SLOW (WDT_SLOW),
        .TO_FAST (WDT_FAST),
        .FREE    (FREE_TO),
        .HALF    (REC_HALF)
    ) u_wdog (
        .clk_i      (clk_i),
        .rstn_i     (rstn_i),
        .scl_i      (scl_sync_ff[1]),
        .sda_i      (sda_sync_ff[1]),
        .disable_i  (ctrl_ff[WDT_DIS_BIT]),
        .fast_i     (ctrl_ff[WDT_FAST_BIT]),
        .bus_free_o (bus_free_o),
        .recover_o  (recover_o),
        .scl_oe_o   (scl_oe_o)
    );
endmodule // ccic_top
`default_nettype wire

/* File: ccic_top_asserts.sv */
// port checker for the control channel configuration block
`timescale 1ns/1ps
`default_nettype none
module ccic_top_asserts
    import ccic_pkg::*;
(
    input wire logic       clk_i,
    input wire logic       rstn_i,
    input wire logic       reg_req_i,
    input wire logic       reg_we_i,
    input wire logic       reg_remote_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       reg_ack_o,
    input wire logic       reg_blocked_o,
    input wire logic       xlat_req_i,
    input wire logic [6:0] xlat_addr_i,
    input wire ccic_xlat_s xlat_o,
    input wire logic       sda_drive_i,
    input wire logic       scl_oe_o,
    input wire logic       sda_oe_o,
    input wire logic       bus_free_o,
    input wire logic       recover_o
);
    // ----------------------------------------------------------------
    // shadow of control b, same write path as the design
    // ----------------------------------------------------------------
    logic [7:0] ctl_ff;
    wire        ctl_wr = reg_req_i && reg_we_i && reg_addr_i == OFS_CTRL_B
                         && !(reg_remote_i && ctl_ff[REM_WR_BLK]);
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) ctl_ff <= RST_CTRL_B;
        else if (ctl_wr) ctl_ff <= reg_wdata_i;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    AST_ACK: assert property (reg_ack_o == $past(reg_req_i))
        else $error("ack not one cycle after request");
    AST_BLK_ON: assert property (reg_req_i && reg_we_i && reg_remote_i
        && ctl_ff[REM_WR_BLK] |=> reg_blocked_o)
        else $error("remote write not refused");
    AST_BLK_OFF: assert property (reg_req_i && !(reg_we_i && reg_remote_i
        && ctl_ff[REM_WR_BLK]) |=> !reg_blocked_o)
        else $error("access refused without cause");
    AST_XV: assert property (xlat_o.valid == $past(xlat_req_i))
        else $error("translate valid misplaced");
    AST_XZERO: assert property (xlat_req_i && xlat_addr_i == 7'h00
        |=> !xlat_o.to_ser && !xlat_o.hit)
        else $error("zero address matched");
    AST_XPASS: assert property (xlat_req_i
        |=> xlat_o.hit || xlat_o.addr == $past(xlat_addr_i))
        else $error("unmatched address altered");
    AST_DLY_LO: assert property (!ctl_ff[SDA_DLY_HI]
        && !$past(ctl_ff[SDA_DLY_HI], 5) |-> sda_oe_o == $past(sda_drive_i, 3))
        else $error("short sda delay wrong");
    AST_DLY_HI: assert property (ctl_ff[SDA_DLY_HI]
        && $past(ctl_ff[SDA_DLY_HI], 5) |-> sda_oe_o == $past(sda_drive_i, 4))
        else $error("long sda delay wrong");
    // half period fixed at the bench value of three cycles
    AST_PULSE: assert property ($rose(scl_oe_o)
        |-> scl_oe_o [*3] ##1 !scl_oe_o [*3])
        else $error("recovery pulse shape wrong");
    AST_OE_REC: assert property (scl_oe_o |-> recover_o)
        else $error("scl driven outside recovery");
    AST_DIS: assert property (ctl_ff[WDT_DIS_BIT] && $past(ctl_ff[WDT_DIS_BIT])
        && $past(ctl_ff[WDT_DIS_BIT], 2) |-> !recover_o && !bus_free_o)
        else $error("watchdog active while disabled");
endmodule // ccic_top_asserts

bind ccic_top ccic_top_asserts ccic_top_asserts_i (
    .clk_i(clk_i), .rstn_i(rstn_i), .reg_req_i(reg_req_i),
    .reg_we_i(reg_we_i), .reg_remote_i(reg_remote_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_ack_o(reg_ack_o), .reg_blocked_o(reg_blocked_o),
    .xlat_req_i(xlat_req_i), .xlat_addr_i(xlat_addr_i), .xlat_o(xlat_o),
    .sda_drive_i(sda_drive_i), .scl_oe_o(scl_oe_o), .sda_oe_o(sda_oe_o),
    .bus_free_o(bus_free_o), .recover_o(recover_o));
`default_nettype wire

/* File: ccic_top_test.sv */
// self-checking bench for the control channel configuration block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin failures++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module ccic_top_test
    import ccic_pkg::*;
;
    logic           clk_i = 1'b0, rstn_i = 1'b0, hold = 1'b0;
    logic           reg_req_i = 1'b0, reg_we_i = 1'b0, reg_remote_i = 1'b0;
    logic           fwd_seq_err_i = 1'b0, xlat_req_i = 1'b0, sda_drive_i = 1'b0;
    logic [7:0]     reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
    logic [6:0]     xlat_addr_i = 7'h00;
    ccic_fwd_addr_s fwd_addr_i = '0;
    ccic_xlat_s     xlat_o;
    logic           reg_ack_o, reg_blocked_o, scl_oe_o, sda_oe_o;
    logic           bus_free_o, recover_o, scl_i, sda_i, scl_o, sda_o, pv;
    int             failures = 0, total_checks = 0, cyc = 0, n, i, flag;
    int             m[6];
    int             msk[6] = '{'h5f, 'hff, 'hfe, 'hfe, 'hfe, 'hfe};
    integer         seed = 32'hd8bb9317;
    logic [7:0]     adr[7] = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h10, 8'h11, 8'h0a};

    ccic_top #(.WDT_SLOW(40), .WDT_FAST(20), .FREE_TO(40), .REC_HALF(3))
    ccic_top_i (.clk_i(clk_i), .rstn_i(rstn_i), .reg_req_i(reg_req_i),
        .reg_we_i(reg_we_i), .reg_remote_i(reg_remote_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .reg_ack_o(reg_ack_o),
        .reg_blocked_o(reg_blocked_o), .fwd_seq_err_i(fwd_seq_err_i),
        .fwd_addr_i(fwd_addr_i), .xlat_req_i(xlat_req_i),
        .xlat_addr_i(xlat_addr_i), .xlat_o(xlat_o), .sda_drive_i(sda_drive_i),
        .scl_i(scl_i), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda_i),
        .sda_o(sda_o),
        .sda_oe_o(sda_oe_o), .bus_free_o(bus_free_o), .recover_o(recover_o));
    ccic_bus_partner ccic_bus_partner_i (.hold_sda_i(hold), .scl_oe_i(scl_oe_o),
        .sda_oe_i(sda_oe_o), .scl_o(scl_i), .sda_o(sda_i));

    initial forever #50 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            give_verdict();
        end
    end
    // ----------------------------------------------------------------
    // model and drivers
    // ----------------------------------------------------------------
    function automatic int idx(input logic [7:0] a);
        return (a >= 8'h06 && a <= 8'h09) ? a - 6 : (a[7:1] == 7'h08) ? a - 12 : -1;
    endfunction
    function automatic logic [7:0] mrd(input logic [7:0] a);
        int k;
        k = idx(a);
        return k < 0 ? 8'h00 : 8'(k == 0 ? m[0] | (flag << 7) : m[k]);
    endfunction
    task automatic give_verdict;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic mreset;
        m = '{0, 'h18, 0, 0, 0, 0};
        flag = 0;
    endtask
    task automatic reg_op(input logic we, rem, input logic [7:0] a, d);
        int k;
        logic blk;
        k = idx(a);
        blk = we && rem && m[0][2];
        reg_req_i <= 1'b1;
        reg_we_i <= we;
        reg_remote_i <= rem;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_req_i <= 1'b0;
        #1;
        `CHK(reg_ack_o, 1'b1)
        `CHK(reg_blocked_o, blk)
        if (!we) `CHK(reg_rdata_o, mrd(a))
        else if (!blk && k >= 0) begin
            m[k] = d & msk[k];
            if (k == 0 && d[6]) flag = 0;
        end
        @(posedge clk_i);
    endtask
    task automatic pulse_seq;
        fwd_seq_err_i <= 1'b1;
        @(posedge clk_i);
        fwd_seq_err_i <= 1'b0;
        flag = 1;
        @(posedge clk_i);
    endtask
    task automatic fwd(input logic [6:0] a);
        fwd_addr_i <= '{1'b1, a};
        @(posedge clk_i);
        fwd_addr_i.valid <= 1'b0;
        if (!m[1][0]) m[1] = {a, 1'b0};
        @(posedge clk_i);
    endtask
    task automatic xl(input logic [6:0] a);
        logic       ts, ht;
        logic [6:0] pa;
        ts = a != 0 && a == m[1][7:1];
        ht = a != 0 && (a == m[4][7:1] || a == m[5][7:1]);
        pa = !ht ? a : a == m[4][7:1] ? m[2][7:1] : m[3][7:1];
        xlat_req_i <= 1'b1;
        xlat_addr_i <= a;
        @(posedge clk_i);
        xlat_req_i <= 1'b0;
        #1;
        `CHK(xlat_o, {1'b1, ts, ht, pa})
        @(posedge clk_i);
    endtask
    task automatic until_hi(ref logic s, input int lim, output int c);
        c = 0;
        while (s !== 1'b1 && c < lim) begin
            @(posedge clk_i);
            #1;
            c++;
        end
        @(posedge clk_i);
    endtask
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        mreset();
        repeat (16) @(posedge clk_i);
        rstn_i <= 1'b1;
        @(posedge clk_i);
        foreach (adr[j]) reg_op(1'b0, 1'b0, adr[j], 8'h00);
        foreach (adr[j]) begin
            reg_op(1'b1, 1'b0, adr[j], 8'($random(seed)));
            reg_op(1'b0, 1'b0, adr[j], 8'h00);
        end
        $display("end of register test");
        reg_op(1'b1, 1'b0, 8'h06, 8'h01);
        pulse_seq();
        reg_op(1'b0, 1'b0, 8'h06, 8'h00);
        reg_op(1'b1, 1'b0, 8'h06, 8'h41);
        reg_op(1'b0, 1'b0, 8'h06, 8'h00);
        reg_op(1'b1, 1'b0, 8'h06, 8'h01);
        pulse_seq();
        reg_op(1'b0, 1'b0, 8'h06, 8'h00);
        $display("end of sequence error test");
        reg_op(1'b1, 1'b0, 8'h07, 8'h30);
        fwd(7'h22);
        reg_op(1'b0, 1'b0, 8'h07, 8'h00);
        reg_op(1'b1, 1'b0, 8'h07, 8'h31);
        fwd(7'h55);
        reg_op(1'b0, 1'b0, 8'h07, 8'h00);
        xl(7'h18);
        reg_op(1'b1, 1'b0, 8'h07, 8'h01);
        xl(7'h00);
        $display("end of serializer address test");
        reg_op(1'b1, 1'b0, 8'h08, 8'h62);
        reg_op(1'b1, 1'b0, 8'h09, 8'h64);
        reg_op(1'b1, 1'b0, 8'h10, 8'h22);
        reg_op(1'b1, 1'b0, 8'h11, 8'h22);
        xl(7'h11);
        reg_op(1'b1, 1'b0, 8'h10, 8'h00);
        xl(7'h11);
        for (i = 0; i < 16; i++) xl(7'($random(seed)));
        $display("end of translate test");
        reg_op(1'b1, 1'b1, 8'h08, 8'h5a);
        reg_op(1'b1, 1'b0, 8'h06, 8'h05);
        reg_op(1'b1, 1'b1, 8'h08, 8'hee);
        reg_op(1'b1, 1'b1, 8'h06, 8'h00);
        reg_op(1'b0, 1'b1, 8'h08, 8'h00);
        xl(7'h11);
        $display("end of write block test");
        // watchdog off here: a held sda would otherwise trigger recovery
        for (i = 0; i < 4; i++) begin
            reg_op(1'b1, 1'b0, 8'h06, 8'((i << 3) | 1));
            sda_drive_i <= 1'b1;
            until_hi(sda_oe_o, 10, n);
            `CHK(n, i < 2 ? 3 : 4)
            sda_drive_i <= 1'b0;
            repeat (6) @(posedge clk_i);
        end
        $display("end of sda delay test");
        reg_op(1'b1, 1'b0, 8'h06, 8'h02);
        hold <= 1'b1;
        until_hi(recover_o, 200, n);
        `CHK(n >= 18 && n <= 30, 1'b1)
        // count scl releases on the bus: the first low phase is already on
        for (n = 0, i = 0; recover_o === 1'b1 && i < 200; i++) begin
            pv = scl_i;
            @(posedge clk_i);
            #1;
            n += int'(!pv && scl_i);
        end
        hold <= 1'b0;
        `CHK(n, REC_PULSES)
        `CHK({scl_o, sda_o}, 2'b00)
        @(posedge clk_i);
        reg_op(1'b1, 1'b0, 8'h06, 8'h00);
        hold <= 1'b1;
        until_hi(recover_o, 200, n);
        `CHK(n >= 38 && n <= 50, 1'b1)
        reg_op(1'b1, 1'b0, 8'h06, 8'h01);
        repeat (2) @(posedge clk_i);
        #1;
        `CHK(recover_o, 1'b0)
        hold <= 1'b0;
        repeat (59) @(posedge clk_i);
        #1;
        `CHK(bus_free_o, 1'b0)
        @(posedge clk_i);
        reg_op(1'b1, 1'b0, 8'h06, 8'h00);
        until_hi(bus_free_o, 100, n);
        `CHK(n >= 36 && n <= 50, 1'b1)
        $display("end of watchdog test");
        rstn_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rstn_i <= 1'b1;
        mreset();
        @(posedge clk_i);
        reg_op(1'b0, 1'b0, 8'h07, 8'h00);
        $display("end of second reset test");
        give_verdict();
    end
endmodule // ccic_top_test
`default_nettype wire
